/* File: ebwd_pkg.sv */
package ebwd_pkg;
  // Memory map boundaries of the 24-bit linear space.
  localparam logic [23:0] EXT_LOW_HI = 24'h007FFF;
  localparam logic [23:0] SYS_LO = 24'h008000;
  localparam logic [23:0] SYS_HI = 24'h00FFFF;
  localparam logic [23:0] EXT1_HI = 24'h1FFFFF;
  localparam logic [23:0] RES_IO_HI = 24'h2007FF;
  localparam logic [23:0] IO_LO = 24'h200800;
  localparam logic [23:0] IO_HI = 24'h3FFFFF;
  localparam logic [23:0] EXT2_LO = 24'h400000;
  localparam logic [23:0] EXT2_HI = 24'hBEFFFF;
  localparam logic [23:0] FLASH_LO = 24'hC00000;
  localparam logic [23:0] FLASH_HI = 24'hC1FFFF;
  localparam logic [23:0] PSRAM_LO = 24'hE00000;
  localparam logic [23:0] PSRAM_HI = 24'hE007FF;
  localparam logic [23:0] FREG_LO = 24'hFFF000;
  // Read value returned for trap locations; the value is arbitrary.
  localparam logic [15:0] TRAP_CODE = 16'hA5A5;
  localparam int NUM_WIN = 4;
  localparam int NUM_REG = 5;

  typedef enum logic [2:0] {
    CLS_EXT_MEM = 3'b000,
    CLS_EXT_IO = 3'b001,
    CLS_SYSTEM = 3'b010,
    CLS_PROGRAM = 3'b011,
    CLS_FLASH_REG = 3'b100,
    CLS_TRAP = 3'b101
  } ebwd_class_t;

  typedef enum logic [1:0] {
    BM_DEMUX16 = 2'b00,
    BM_MUX16 = 2'b01,
    BM_MUX8 = 2'b10,
    BM_DEMUX8 = 2'b11
  } ebwd_mode_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_ADDR = 3'b010,
    S_DATA = 3'b011,
    S_END = 3'b100
  } ebwd_state_t;

  typedef struct packed {
    logic write;
    logic byteAcc;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ebwd_req_t;

  // window_select_cfg: base is address bits 23..12, block is 4 Kbytes shl sizeCode.
  typedef struct packed {
    logic enable;
    logic [11:0] base;
    logic [3:0] sizeCode;
  } ebwd_window_t;

  // region_timing_cfg.
  typedef struct packed {
    logic [1:0] addrCycles;
    logic [3:0] waitStates;
  } ebwd_timing_t;

  // region_function_cfg.
  typedef struct packed {
    logic csEnable;
    logic expansionBus;
    ebwd_mode_t busMode;
  } ebwd_func_t;
endpackage

/* File: ebwd_external_bus_ctrl.sv */
module ebwd_external_bus_ctrl
  import ebwd_pkg::*;
(
  input logic clk,
  input logic reset,
  input logic ce,
  input logic reqValid,
  input ebwd_req_t req,
  output logic reqReady,
  output logic respValid,
  output logic [15:0] respData,
  output logic respTrap,
  output logic respInternal,
  input logic [15:0] intRdata,
  input logic intUndefined,
  input logic singleChip,
  input logic [2:0] segLineCount,
  input ebwd_window_t windowCfg [NUM_WIN],
  input ebwd_timing_t regionTiming [NUM_REG],
  input ebwd_func_t regionFunc [NUM_REG],
  input logic refClkIn,
  output logic busRefClkOut,
  output logic [15:0] addrPortOut,
  input logic [15:0] dataPortIn,
  output logic [15:0] dataPortOut,
  output logic dataPortOeLo,
  output logic dataPortOeHi,
  output logic [7:0] segLinesOut,
  output logic [3:0] chipSelN,
  output logic addrLatchEn,
  output logic readN,
  output logic writeN,
  output logic byteHighN,
  output logic inOrderAccess,
  output logic expBusSel,
  output ebwd_mode_t busModeOut,
  output logic [2:0] activeRegion
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the reference clock and the data pins.
  logic refSync1_q, refSync2_q, refPrev_q;
  logic [15:0] dataSync1_q, dataSync2_q;
  logic refRise;

  assign refRise = refSync2_q & ~refPrev_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      refSync1_q <= 1'b0;
      refSync2_q <= 1'b0;
      refPrev_q <= 1'b0;
      dataSync1_q <= 16'h0000;
      dataSync2_q <= 16'h0000;
    end else if (ce) begin
      refSync1_q <= refClkIn;
      refSync2_q <= refSync1_q;
      refPrev_q <= refSync2_q;
      dataSync1_q <= dataPortIn;
      dataSync2_q <= dataSync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address classification and window match.
  ebwd_class_t reqClass;
  logic [NUM_WIN-1:0] winHit;
  logic [2:0] reqRegion;

  always_comb begin
    logic [23:0] a;
    a = req.addr;
    // Segment 0 upper half holds data RAMs and both register spaces.
    if (a <= EXT_LOW_HI) reqClass = CLS_EXT_MEM;
    else if (a <= SYS_HI) reqClass = CLS_SYSTEM;
    else if (a <= EXT1_HI) reqClass = CLS_EXT_MEM;
    else if (a <= RES_IO_HI) reqClass = CLS_TRAP;
    else if (a <= IO_HI) reqClass = CLS_EXT_IO;
    else if (a <= EXT2_HI) reqClass = CLS_EXT_MEM;
    else if (a >= FLASH_LO && a <= FLASH_HI) reqClass = CLS_PROGRAM;
    else if (a >= PSRAM_LO && a <= PSRAM_HI) reqClass = CLS_PROGRAM;
    else if (a >= FREG_LO) reqClass = CLS_FLASH_REG;
    else reqClass = CLS_TRAP;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi++) begin : g_win
      logic [11:0] lowMask;
      assign lowMask = 12'((12'h001 << windowCfg[gi].sizeCode) - 12'h001);
      assign winHit[gi] = windowCfg[gi].enable &&
        (((req.addr[23:12] ^ windowCfg[gi].base) & ~lowMask) == 12'h000);
    end
  endgenerate

  // Later windows override earlier ones, so 4 wins over all.
  always_comb begin
    reqRegion = 3'd0;
    for (int i = 0; i < NUM_WIN; i++) begin
      if (winHit[i]) reqRegion = 3'(i + 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer, stepped on reference clock rising edges.
  ebwd_state_t state_q, state_d;
  ebwd_req_t acc_q, acc_d;
  ebwd_mode_t mode_q, mode_d;
  ebwd_timing_t tim_q, tim_d;
  logic [3:0] cnt_q, cnt_d;
  logic phase_q, phase_d;
  logic [7:0] lowBuf_q, lowBuf_d;
  logic reqReady_q, reqReady_d, respValid_q, respValid_d;
  logic [15:0] respData_q, respData_d;
  logic respTrap_q, respTrap_d, respInt_q, respInt_d;
  logic bus_reference_clock_out_q, bus_reference_clock_out_d;
  logic [15:0] addrOut_q, addrOut_d, dataOut_q, dataOut_d;
  logic oeLo_q, oeLo_d, oeHi_q, oeHi_d;
  logic [7:0] seg_q, seg_d;
  logic [3:0] csN_q, csN_d;
  logic ale_q, ale_d, rdN_q, rdN_d, wrN_q, wrN_d, bheN_q, bheN_d;
  logic inOrder_q, inOrder_d, exp_q, exp_d;
  logic [2:0] region_q, region_d;

  always_comb begin
    logic is8, isMux, last;
    logic [23:0] pa;
    logic [7:0] segMask, rb;
    state_d = state_q;
    acc_d = acc_q;
    mode_d = mode_q;
    tim_d = tim_q;
    cnt_d = cnt_q;
    phase_d = phase_q;
    lowBuf_d = lowBuf_q;
    reqReady_d = reqReady_q;
    respValid_d = 1'b0;
    respData_d = respData_q;
    respTrap_d = respTrap_q;
    respInt_d = respInt_q;
    bus_reference_clock_out_d = refSync2_q;
    addrOut_d = addrOut_q;
    dataOut_d = dataOut_q;
    oeLo_d = oeLo_q;
    oeHi_d = oeHi_q;
    seg_d = seg_q;
    csN_d = csN_q;
    ale_d = ale_q;
    rdN_d = rdN_q;
    wrN_d = wrN_q;
    bheN_d = bheN_q;
    inOrder_d = inOrder_q;
    exp_d = exp_q;
    region_d = region_q;
    is8 = (mode_q == BM_MUX8) || (mode_q == BM_DEMUX8);
    isMux = (mode_q == BM_MUX8) || (mode_q == BM_MUX16);
    // Words on an 8-bit bus go as two bytes, low address first.
    last = !is8 || acc_q.byteAcc || phase_q;
    pa = acc_q.addr;
    if (is8 && !acc_q.byteAcc) pa = {acc_q.addr[23:1], phase_q};
    if (!is8 && !acc_q.byteAcc) pa = {acc_q.addr[23:1], 1'b0};
    segMask = 8'((9'h001 << segLineCount) - 9'h001);
    rb = (!is8 && acc_q.addr[0]) ? dataSync2_q[15:8] : dataSync2_q[7:0];
    case (state_q)
      S_IDLE: begin
        reqReady_d = 1'b1;
        if (reqValid && reqReady_q) begin
          reqReady_d = 1'b0;
          acc_d = req;
          if ((reqClass == CLS_EXT_MEM || reqClass == CLS_EXT_IO) && !singleChip) begin
            mode_d = regionFunc[reqRegion].busMode;
            tim_d = regionTiming[reqRegion];
            exp_d = regionFunc[reqRegion].expansionBus;
            region_d = reqRegion;
            inOrder_d = (reqClass == CLS_EXT_IO);
            phase_d = 1'b0;
            state_d = S_START;
          end else begin
            // Internal answers come the next cycle; trap areas read the trap code.
            respValid_d = 1'b1;
            respInt_d = 1'b1;
            respTrap_d = (reqClass == CLS_TRAP) || (reqClass == CLS_EXT_MEM) ||
              (reqClass == CLS_EXT_IO) || intUndefined;
            if (req.write) respData_d = 16'h0000;
            else if (respTrap_d) respData_d = TRAP_CODE;
            else respData_d = intRdata;
          end
        end
      end
      S_START: begin
        if (refRise) begin
          seg_d = acc_q.addr[23:16] & segMask;
          csN_d = 4'hF;
          // Window 4 has no pin of its own; expansion bus cycles drive none.
          if (regionFunc[region_q].csEnable && !exp_q && region_q != 3'd4) begin
            csN_d[region_q[1:0]] = 1'b0;
          end
          state_d = S_ADDR;
          cnt_d = {2'b00, tim_q.addrCycles};
        end
      end
      S_ADDR: begin
        addrOut_d = pa[15:0];
        bheN_d = is8 || (acc_q.byteAcc && !acc_q.addr[0]);
        if (isMux) begin
          dataOut_d = pa[15:0];
          oeLo_d = 1'b1;
          oeHi_d = 1'b1;
          ale_d = 1'b1;
        end
        if (refRise) begin
          if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
          end else begin
            ale_d = 1'b0;
            cnt_d = tim_q.waitStates;
            state_d = S_DATA;
            rdN_d = acc_q.write;
            wrN_d = !acc_q.write;
            oeLo_d = acc_q.write;
            oeHi_d = acc_q.write && !is8;
            if (is8) dataOut_d = {8'h00, phase_q ? acc_q.wdata[15:8] : acc_q.wdata[7:0]};
            else if (acc_q.byteAcc) dataOut_d = {acc_q.wdata[7:0], acc_q.wdata[7:0]};
            else dataOut_d = acc_q.wdata;
          end
        end
      end
      S_DATA: begin
        if (refRise) begin
          if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
          end else begin
            rdN_d = 1'b1;
            wrN_d = 1'b1;
            oeLo_d = 1'b0;
            oeHi_d = 1'b0;
            if (acc_q.byteAcc) respData_d = {8'h00, rb};
            else if (is8) respData_d = {dataSync2_q[7:0], lowBuf_q};
            else respData_d = dataSync2_q;
            if (acc_q.write) respData_d = 16'h0000;
            if (last) begin
              state_d = S_END;
            end else begin
              lowBuf_d = dataSync2_q[7:0];
              phase_d = 1'b1;
              cnt_d = {2'b00, tim_q.addrCycles};
              state_d = S_ADDR;
            end
          end
        end
      end
      S_END: begin
        csN_d = 4'hF;
        bheN_d = 1'b1;
        exp_d = 1'b0;
        inOrder_d = 1'b0;
        respValid_d = 1'b1;
        respTrap_d = 1'b0;
        respInt_d = 1'b0;
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= S_IDLE;
      acc_q <= '0;
      mode_q <= BM_DEMUX16;
      tim_q <= '0;
      cnt_q <= 4'h0;
      phase_q <= 1'b0;
      lowBuf_q <= 8'h00;
      reqReady_q <= 1'b0;
      respValid_q <= 1'b0;
      respData_q <= 16'h0000;
      respTrap_q <= 1'b0;
      respInt_q <= 1'b0;
      bus_reference_clock_out_q <= 1'b0;
      addrOut_q <= 16'h0000;
      dataOut_q <= 16'h0000;
      oeLo_q <= 1'b0;
      oeHi_q <= 1'b0;
      seg_q <= 8'h00;
      csN_q <= 4'hF;
      ale_q <= 1'b0;
      rdN_q <= 1'b1;
      wrN_q <= 1'b1;
      bheN_q <= 1'b1;
      inOrder_q <= 1'b0;
      exp_q <= 1'b0;
      region_q <= 3'd0;
    end else if (ce) begin
      state_q <= state_d;
      acc_q <= acc_d;
      mode_q <= mode_d;
      tim_q <= tim_d;
      cnt_q <= cnt_d;
      phase_q <= phase_d;
      lowBuf_q <= lowBuf_d;
      reqReady_q <= reqReady_d;
      respValid_q <= respValid_d;
      respData_q <= respData_d;
      respTrap_q <= respTrap_d;
      respInt_q <= respInt_d;
      bus_reference_clock_out_q <= bus_reference_clock_out_d;
      addrOut_q <= addrOut_d;
      dataOut_q <= dataOut_d;
      oeLo_q <= oeLo_d;
      oeHi_q <= oeHi_d;
      seg_q <= seg_d;
      csN_q <= csN_d;
      ale_q <= ale_d;
      rdN_q <= rdN_d;
      wrN_q <= wrN_d;
      bheN_q <= bheN_d;
      inOrder_q <= inOrder_d;
      exp_q <= exp_d;
      region_q <= region_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from its register.
  assign reqReady = reqReady_q;
  assign respValid = respValid_q;
  assign respData = respData_q;
  assign respTrap = respTrap_q;
  assign respInternal = respInt_q;
  assign busRefClkOut = bus_reference_clock_out_q;
  assign addrPortOut = addrOut_q;
  assign dataPortOut = dataOut_q;
  assign dataPortOeLo = oeLo_q;
  assign dataPortOeHi = oeHi_q;
  assign segLinesOut = seg_q;
  assign chipSelN = csN_q;
  assign addrLatchEn = ale_q;
  assign readN = rdN_q;
  assign writeN = wrN_q;
  assign byteHighN = bheN_q;
  assign inOrderAccess = inOrder_q;
  assign expBusSel = exp_q;
  assign busModeOut = mode_q;
  assign activeRegion = region_q;

endmodule // ebwd_external_bus_ctrl

/* File: ebwd_external_bus_ctrl_assertions.sv */
module ebwd_external_bus_ctrl_assertions
  import ebwd_pkg::*;
(
  input logic clk,
  input logic reset,
  input logic ce,
  input logic reqValid,
  input ebwd_req_t req,
  input logic reqReady,
  input logic respValid,
  input logic [15:0] respData,
  input logic respTrap,
  input logic respInternal,
  input logic [15:0] intRdata,
  input logic intUndefined,
  input logic singleChip,
  input logic refClkIn,
  input logic busRefClkOut,
  input logic [3:0] chipSelN,
  input logic addrLatchEn,
  input logic readN,
  input logic writeN,
  input logic expBusSel
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_take;
    reqValid && reqReady && ce;
  endsequence
  sequence s_trap;
    respValid && respTrap && respData == TRAP_CODE;
  endsequence
  a_take_busy: assert property (s_take |=> !reqReady)
    else $error("ready stayed high after a take");
  a_int_read: assert property (s_take ##0 (!req.write && !req.byteAcc && !intUndefined
    && req.addr >= SYS_LO && req.addr <= SYS_HI) |=> respValid && respInternal && !respTrap
    && respData == $past(intRdata)) else $error("internal read answer wrong");
  a_trap_read: assert property (s_take ##0 (!req.write && ((req.addr > EXT1_HI && req.addr <= RES_IO_HI)
    || (intUndefined && req.addr >= SYS_LO && req.addr <= SYS_HI))) |=> s_trap)
    else $error("trap location did not return the trap code");
  a_single_chip: assert property (s_take ##0 (singleChip && !req.write && req.addr >= EXT2_LO
    && req.addr <= EXT2_HI) |-> ##[1:40] s_trap) else $error("single chip access not trapped");
  a_one_select: assert property ($onehot0(~chipSelN))
    else $error("more than one chip select active");
  a_exp_no_cs: assert property (expBusSel |-> chipSelN == 4'hF)
    else $error("chip select during expansion bus cycle");
  a_ale_no_strobe: assert property (addrLatchEn |-> readN && writeN)
    else $error("strobe during address phase");
  a_one_strobe: assert property (!readN |-> writeN)
    else $error("read and write strobes together");
  a_ref_delay: assert property ($past({reset, ce}) == 2'b01 && $past({reset, ce}, 2) == 2'b01
    && $past({reset, ce}, 3) == 2'b01 |-> busRefClkOut == $past(refClkIn, 3))
    else $error("reference clock output delay wrong");
endmodule // ebwd_external_bus_ctrl_assertions

bind ebwd_external_bus_ctrl ebwd_external_bus_ctrl_assertions ebwd_external_bus_ctrl_assertions_i (
  .clk, .reset, .ce, .reqValid, .req, .reqReady, .respValid, .respData, .respTrap, .respInternal,
  .intRdata, .intUndefined, .singleChip, .refClkIn, .busRefClkOut, .chipSelN, .addrLatchEn,
  .readN, .writeN, .expBusSel
);

/* File: ebwd_ext_mem_model.sv */
module ebwd_ext_mem_model #(
  parameter logic [15:0] KEY = 16'h3C3C
) (
  input logic clk,
  input logic readN,
  input logic [15:0] addr,
  output logic [15:0] dataIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] last = 16'h0;
  logic [2:0] hold = 3'h0;
  // Data is held a few clocks past the strobe, then inverted so a late sample never looks right.
  always @(posedge clk) begin
    if (!readN) begin
      last <= KEY ^ addr;
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  // The 16-bit address port value enters the pattern, so the two bytes of an 8-bit word read differ.
  assign dataIn = !readN ? KEY ^ addr : (hold != 3'h0 ? last : ~last);
endmodule // ebwd_ext_mem_model

/* File: tb_ebwd_external_bus_ctrl.sv */
module tb_ebwd_external_bus_ctrl
  import ebwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] KEY = 16'h3C3C;
  logic clk = 0, reset = 1, ce = 1, reqValid = 0, intUndefined = 0, singleChip = 0, refClkIn = 0;
  logic reqReady, respValid, respTrap, respInternal, busRefClkOut, dataPortOeLo, dataPortOeHi;
  logic addrLatchEn, readN, writeN, byteHighN, inOrderAccess, expBusSel;
  logic [15:0] respData, addrPortOut, dataPortIn, dataPortOut, rd, wdSeen;
  logic [15:0] intRdata = 16'h0;
  logic [7:0] segLinesOut, segSeen;
  logic [3:0] chipSelN, csSeen;
  logic [2:0] activeRegion;
  logic [2:0] segLineCount = 3'h0;
  logic ioSeen, aleSeen, expSeen, wrSeen, aleBad, hiSeen;
  ebwd_mode_t busModeOut;
  ebwd_req_t req = '0;
  ebwd_window_t windowCfg [NUM_WIN];
  ebwd_timing_t regionTiming [NUM_REG];
  ebwd_func_t regionFunc [NUM_REG];
  logic [23:0] extAddr [6] = '{24'h010000, 24'h420000, 24'h441000, 24'h482000, 24'h480010, 24'h200800};
  logic [2:0] extReg [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
  int errorCnt = 0, checks = 0;

  ebwd_external_bus_ctrl ebwd_external_bus_ctrl_i (
    .clk, .reset, .ce, .reqValid, .req, .reqReady, .respValid, .respData, .respTrap,
    .respInternal, .intRdata, .intUndefined, .singleChip, .segLineCount, .windowCfg, .regionTiming,
    .regionFunc, .refClkIn, .busRefClkOut, .addrPortOut, .dataPortIn, .dataPortOut, .dataPortOeLo,
    .dataPortOeHi, .segLinesOut, .chipSelN, .addrLatchEn, .readN, .writeN, .byteHighN, .inOrderAccess,
    .expBusSel, .busModeOut, .activeRegion
  );
  ebwd_ext_mem_model #(.KEY(KEY)) ebwd_ext_mem_model_i (.clk, .readN, .addr(addrPortOut), .dataIn(dataPortIn));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic b, input logic [23:0] a, input logic [15:0] d);
    int n;
    @(negedge clk);
    reqValid = 1'b1;
    req = '{w, b, a, d};
    while (reqReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    reqValid = 1'b0;
    {csSeen, segSeen, ioSeen, aleSeen, expSeen, wrSeen, aleBad, hiSeen, wdSeen} = {4'hF, 30'h0};
    for (n = 0; n < 500 && respValid !== 1'b1; n++) begin
      csSeen &= chipSelN;
      ioSeen |= inOrderAccess;
      expSeen |= expBusSel;
      wrSeen |= !writeN;
      hiSeen |= !byteHighN;
      if (!writeN) wdSeen = dataPortOut & {{8{dataPortOeHi}}, {8{dataPortOeLo}}};
      if (chipSelN != 4'hF || expBusSel) segSeen = segLinesOut;
      if (addrLatchEn) begin
        aleSeen = 1'b1;
        aleBad |= dataPortOut !== a[15:0];
      end
      @(negedge clk);
    end
    chk(respValid, 1'b1);
    rd = respData;
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial forever #5 clk = ~clk;
  // The reference clock has its own phase so edges drift against the system clock.
  initial begin
    #17;
    forever #62.5 refClkIn = ~refClkIn;
  end
  initial begin
    #50000;
    errorCnt++;
    wrapUp();
  end

  initial begin
    windowCfg = '{'{1'b1, 12'h400, 4'h8}, '{1'b1, 12'h440, 4'h4}, '{1'b1, 12'h480, 4'h4}, '{1'b1, 12'h480, 4'h0}};
    regionTiming = '{'{2'h0, 4'h0}, '{2'h1, 4'h2}, '{2'h0, 4'h1}, '{2'h0, 4'h0}, '{2'h0, 4'h0}};
    regionFunc = '{'{1'b1, 1'b0, BM_DEMUX16}, '{1'b1, 1'b0, BM_MUX16}, '{1'b1, 1'b0, BM_DEMUX16},
      '{1'b1, 1'b0, BM_MUX16}, '{1'b1, 1'b1, BM_DEMUX16}};
    repeat (10) @(negedge clk);
    reset = 0;
    for (int s = 0; s < 2; s++) begin
      segLineCount = s ? 3'h7 : 3'h0;
      for (int i = 0; i < 6; i++) begin
        acc(1'b0, 1'b0, extAddr[i], 16'h0);
        chk(rd, KEY ^ extAddr[i][15:0]);
        chk(respTrap, 1'b0);
        chk(activeRegion, extReg[i]);
        chk(csSeen, extReg[i] == 3'h4 ? 4'hF : 4'(~(4'h1 << extReg[i])));
        chk(busModeOut, regionFunc[extReg[i]].busMode);
        chk(aleSeen, regionFunc[extReg[i]].busMode == BM_MUX16);
        chk(aleBad, 1'b0);
        chk(hiSeen, 1'b1);
        chk(ioSeen, extAddr[i] >= IO_LO && extAddr[i] <= IO_HI);
        chk(expSeen, extReg[i] == 3'h4);
        chk(segSeen, extAddr[i][23:16] & ((8'h1 << segLineCount) - 8'h1));
      end
      $display("external window test %0d done", s);
    end
    acc(1'b0, 1'b1, 24'h010001, 16'h0);
    chk(rd, {8'h0, KEY[15:8]});
    acc(1'b1, 1'b0, 24'h010002, 16'hBEEF);
    chk(wrSeen, 1'b1);
    chk(wdSeen, 16'hBEEF);
    chk(respTrap, 1'b0);
    // Default region switched to the 8-bit modes: a word goes as two bytes, low first.
    regionFunc[0].busMode = BM_DEMUX8;
    acc(1'b0, 1'b0, 24'h010004, 16'h0);
    chk(rd, {KEY[7:0] ^ 8'h05, KEY[7:0] ^ 8'h04});
    chk(hiSeen, 1'b0);
    regionFunc[0].busMode = BM_MUX8;
    acc(1'b0, 1'b1, 24'h010006, 16'h0);
    chk(rd, {8'h00, KEY[7:0] ^ 8'h06});
    chk(aleSeen, 1'b1);
    chk(aleBad, 1'b0);
    regionFunc[0].busMode = BM_DEMUX16;
    $display("byte and write test done");
    intRdata = 16'h1234;
    acc(1'b0, 1'b0, SYS_LO, 16'h0);
    chk(rd, 16'h1234);
    chk(respInternal, 1'b1);
    intUndefined = 1'b1;
    acc(1'b0, 1'b0, SYS_LO, 16'h0);
    chk(rd, TRAP_CODE);
    intUndefined = 1'b0;
    acc(1'b0, 1'b0, 24'h200000, 16'h0);
    chk(respTrap, 1'b1);
    chk(rd, TRAP_CODE);
    acc(1'b1, 1'b0, 24'h200000, 16'h0000);
    chk(respTrap, 1'b1);
    chk(rd, 16'h0000);
    chk(wrSeen, 1'b0);
    // With the clock enable low an offered request must not be taken.
    @(negedge clk);
    ce = 1'b0;
    reqValid = 1'b1;
    req = '{1'b0, 1'b0, SYS_LO, 16'h0};
    repeat (4) @(negedge clk);
    chk(respValid, 1'b0);
    chk(reqReady, 1'b1);
    reqValid = 1'b0;
    ce = 1'b1;
    $display("internal and trap test done");
    singleChip = 1'b1;
    acc(1'b0, 1'b0, 24'h420000, 16'h0);
    chk(respTrap, 1'b1);
    chk(csSeen, 4'hF);
    singleChip = 1'b0;
    $display("single chip test done");
    wrapUp();
  end
endmodule // tb_ebwd_external_bus_ctrl
